// ===== common/cpp_pkg.sv
package cpp_pkg;
  localparam int unsigned CLK_HZ          = 200_000_000;
  localparam int unsigned HOLD_ON_MS      = 1000;
  localparam int unsigned HOLD_CFG_MS     = 5000;
  localparam int unsigned ERR_SHOW_MS     = 5000;
  localparam int unsigned DEBOUNCE_US     = 10;
  localparam int unsigned HOLD_ON_CYC     = HOLD_ON_MS * (CLK_HZ / 1000);
  localparam int unsigned HOLD_CFG_CYC    = HOLD_CFG_MS * (CLK_HZ / 1000);
  localparam int unsigned ERR_SHOW_CYC    = ERR_SHOW_MS * (CLK_HZ / 1000);
  localparam int unsigned DEBOUNCE_CYC    = DEBOUNCE_US * (CLK_HZ / 1_000_000);
  localparam logic [11:0] ADDR_CTRL_NEW   = 12'd1000;
  localparam logic [11:0] ADDR_CTRL_OLD   = 12'd2000;
  localparam logic [11:0] ADDR_MODULE_MAX = 12'd999;
  localparam logic [3:0]  YELLOW_ID_BASE  = 4'h1;
  localparam logic [3:0]  GREEN_ID_BASE   = 4'h8;
  localparam int unsigned SLAVES_PER_LINE = 4;
  localparam int unsigned LEGACY_MODULES  = 64;

  typedef enum logic [2:0] {
    PS_OFF     = 3'b000,
    PS_STARTUP = 3'b001,
    PS_ON      = 3'b010,
    PS_ERRSHOW = 3'b011,
    PS_CONFIG  = 3'b100
  } cpp_pwr_t;

  typedef struct packed {
    logic green;
    logic red;
  } cpp_led_t;

  typedef struct packed {
    logic       connected;
    logic       onGreenLine;
    logic [2:0] order;
  } cpp_chain_t;
endpackage

// ===== src/cpp_panel_control.sv
// Behaviour
// - Off, one-second hold: supply on, green
// - On, one-second hold: supply off, dark
// - Five-second hold while off enters bitrate configuration mode
// - Start error: red five seconds, then off
// - Running error: stay on, red steady
// - Button and remote share one supply
// - High voltage only with loop current
// - Loop open stops high voltage on the next clock edge
// - Unconnected slave keeps connector and number LEDs dark
// - Slave shows line colour and order
// - Line ids 1-5 yellow, 8-12 green
// - Addresses 1000, 2000, modules 0-999
// - Four slaves per line, eight total
// - 64 legacy modules per line
// - Master: upper yellow, lower green connector LEDs
`timescale 1ns/1ps
module cpp_panel_control
  import cpp_pkg::*;
#(
  parameter int unsigned HoldOnCyc  = HOLD_ON_CYC,
  parameter int unsigned HoldCfgCyc = HOLD_CFG_CYC,
  parameter int unsigned ErrShowCyc = ERR_SHOW_CYC,
  parameter int unsigned DebCyc     = DEBOUNCE_CYC
) (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       powerButton,
  input  wire logic       remoteOn,
  input  wire logic       remoteOff,
  input  wire logic       supplyError,
  input  wire logic       cfgDone,
  input  wire logic       isMaster,
  input  wire logic       chainConnected,
  input  wire logic       chainOnGreen,
  input  wire logic [2:0] chainOrder,
  input  wire logic       floatingLoopSense,
  input  wire logic       groundedLoopSense,
  input  wire logic       hvRequest,
  input  wire logic [6:0] legacyModuleCount,
  output logic            supplyOn,
  output cpp_led_t        state_indicator_led,
  output logic            configMode,
  output logic            hvEnable,
  output cpp_led_t        upperConnLed,
  output cpp_led_t        lowerConnLed,
  output logic [3:0]      numberLeds,
  output logic [3:0]      chain_position_id,
  output logic [11:0]     ownAddress,
  output logic            legacyOverflow
);
  // Counters are sized for the defaults; refuse what they cannot hold
  if (HoldOnCyc == 0) begin
    $error("cpp_panel_control: HoldOnCyc must be non-zero");
  end
  if (HoldCfgCyc <= HoldOnCyc) begin
    $error("cpp_panel_control: HoldCfgCyc must exceed HoldOnCyc");
  end
  if (ErrShowCyc == 0) begin
    $error("cpp_panel_control: ErrShowCyc must be non-zero");
  end
  if (DebCyc == 0 || DebCyc > 65536) begin
    $error("cpp_panel_control: DebCyc must fit the 16-bit debounce counter");
  end

  // Reset enters asynchronously but leaves in step with the clock
  logic [1:0] rstSync_q;
  logic       rstInt_n;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) rstSync_q <= 2'b00;
    else        rstSync_q <= {rstSync_q[0], 1'b1};
  end
  assign rstInt_n = rstSync_q[1];

  // Debounce: level must hold steady for DebCyc cycles
  // Pin idles low, so reset to released avoids a false press
  logic        btn_q;
  logic [15:0] debCnt_q;
  always_ff @(posedge sys_clk or negedge rstInt_n) begin
    if (!rstInt_n) begin
      btn_q    <= 1'b0;
      debCnt_q <= 16'h0000;
    end else if (powerButton == btn_q) begin
      debCnt_q <= 16'h0000;
    end else if (debCnt_q >= 16'(DebCyc - 1)) begin
      btn_q    <= powerButton;
      debCnt_q <= 16'h0000;
    end else begin
      debCnt_q <= debCnt_q + 16'h0001;
    end
  end

  // Hold timer; action fires on release so a 5 s hold is never also a toggle
  // Counter saturates at the config count so a long hold never wraps
  logic [31:0] holdCnt_q;
  logic        btnPrev_q;
  logic        release1s;
  logic        reach5s;
  always_ff @(posedge sys_clk or negedge rstInt_n) begin
    if (!rstInt_n) begin
      holdCnt_q <= 32'h0000_0000;
      btnPrev_q <= 1'b0;
    end else begin
      btnPrev_q <= btn_q;
      if (!btn_q)                        holdCnt_q <= 32'h0000_0000;
      else if (holdCnt_q < HoldCfgCyc)   holdCnt_q <= holdCnt_q + 32'h0000_0001;
    end
  end
  // Short press leaves no trace; 5 s hold is claimed by config
  assign release1s = btnPrev_q && !btn_q && holdCnt_q >= HoldOnCyc
                     && holdCnt_q < HoldCfgCyc;
  assign reach5s   = btn_q && holdCnt_q == HoldCfgCyc - 1;

  // Remote commands act only in OFF and ON; other states ignore them
  // Start error is sampled in the single STARTUP cycle
  cpp_pwr_t    pwr_q;
  logic [31:0] errCnt_q;
  logic        runErr_q;
  always_ff @(posedge sys_clk or negedge rstInt_n) begin
    if (!rstInt_n) begin
      pwr_q    <= PS_OFF;
      errCnt_q <= 32'h0000_0000;
      runErr_q <= 1'b0;
    end else begin
      unique case (pwr_q)
        PS_OFF: begin
          runErr_q <= 1'b0;
          if (reach5s) pwr_q <= PS_CONFIG;
          else if (release1s || remoteOn) pwr_q <= PS_STARTUP;
        end
        PS_STARTUP: begin
          errCnt_q <= 32'h0000_0000;
          if (supplyError) pwr_q <= PS_ERRSHOW;
          else             pwr_q <= PS_ON;
        end
        PS_ON: begin
          if (supplyError) runErr_q <= 1'b1;
          if (release1s || remoteOff) pwr_q <= PS_OFF;
        end
        PS_ERRSHOW: begin
          errCnt_q <= errCnt_q + 32'h0000_0001;
          if (errCnt_q >= ErrShowCyc - 1) pwr_q <= PS_OFF;
        end
        PS_CONFIG: begin
          if (cfgDone) pwr_q <= PS_OFF;
        end
        default: pwr_q <= PS_OFF;
      endcase
    end
  end

  // Outputs registered from state
  always_ff @(posedge sys_clk or negedge rstInt_n) begin
    if (!rstInt_n) begin
      supplyOn            <= 1'b0;
      state_indicator_led <= '0;
      configMode          <= 1'b0;
    end else begin
      supplyOn   <= (pwr_q == PS_ON) || (pwr_q == PS_STARTUP);
      configMode <= (pwr_q == PS_CONFIG);
      unique case (pwr_q)
        PS_ON:      state_indicator_led <= runErr_q ? cpp_led_t'{green: 1'b0, red: 1'b1}
                                           : cpp_led_t'{green: 1'b1, red: 1'b0};
        PS_ERRSHOW: state_indicator_led <= cpp_led_t'{green: 1'b0, red: 1'b1};
        PS_CONFIG:  state_indicator_led <= cpp_led_t'{green: 1'b1, red: 1'b0};
        default:    state_indicator_led <= '0;
      endcase
    end
  end

  // High voltage needs supply and current in both loops; no ramp on drop
  // Either loop source opening drops the enable on the next edge
  logic loopOk;
  assign loopOk = floatingLoopSense && groundedLoopSense;
  always_ff @(posedge sys_clk or negedge rstInt_n) begin
    if (!rstInt_n) hvEnable <= 1'b0;
    else           hvEnable <= hvRequest && loopOk && pwr_q == PS_ON;
  end

  // Address is fixed for this controller; the legacy count only flags excess
  always_ff @(posedge sys_clk or negedge rstInt_n) begin
    if (!rstInt_n) begin
      ownAddress     <= 12'h000;
      legacyOverflow <= 1'b0;
    end else begin
      ownAddress     <= ADDR_CTRL_NEW;
      legacyOverflow <= legacyModuleCount > 7'(LEGACY_MODULES);
    end
  end

  // Chain indication; order 0 is shown as is, orders past four read as unlinked
  logic       slaveValid;
  logic [3:0] lineBase;
  assign slaveValid = chainConnected && chainOrder < 3'(SLAVES_PER_LINE + 1);
  assign lineBase   = chainOnGreen ? GREEN_ID_BASE : YELLOW_ID_BASE;
  always_ff @(posedge sys_clk or negedge rstInt_n) begin
    if (!rstInt_n) begin
      upperConnLed      <= '0;
      lowerConnLed      <= '0;
      numberLeds        <= 4'h0;
      chain_position_id <= 4'h0;
    end else begin
      if (isMaster) begin
        upperConnLed      <= '{green: 1'b1, red: 1'b1};
        lowerConnLed      <= '{green: 1'b1, red: 1'b0};
        numberLeds        <= 4'h0;
        chain_position_id <= YELLOW_ID_BASE;
      end else if (slaveValid) begin
        upperConnLed      <= chainOnGreen ? cpp_led_t'{green: 1'b1, red: 1'b0}
                                          : cpp_led_t'{green: 1'b1, red: 1'b1};
        lowerConnLed      <= '0;
        numberLeds        <= {1'b0, chainOrder};
        chain_position_id <= lineBase + {1'b0, chainOrder};
      end else begin
        upperConnLed      <= '0;
        lowerConnLed      <= '0;
        numberLeds        <= 4'h0;
        chain_position_id <= 4'h0;
      end
    end
  end
endmodule

// ===== test/cpp_chain_peer.sv
`timescale 1ns/1ps
module cpp_chain_peer (
  input  wire logic       sys_clk,
  input  wire logic       linkUp,
  input  wire logic       greenLine,
  input  wire logic [2:0] position,
  output logic            chainConnected,
  output logic            chainOnGreen,
  output logic [2:0]      chainOrder
);
  initial chainOrder = 3'h0;
  always @(posedge sys_clk) begin
    chainConnected <= linkUp;
    chainOnGreen   <= greenLine;
    // Released line keeps toggling so stale order is never trusted
    chainOrder     <= linkUp ? position : ~chainOrder;
  end
endmodule

// ===== test/cpp_panel_control_properties.sv
`timescale 1ns/1ps
module cpp_panel_control_properties
  import cpp_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        isMaster,
  input wire logic        chainConnected,
  input wire logic        chainOnGreen,
  input wire logic [2:0]  chainOrder,
  input wire logic        floatingLoopSense,
  input wire logic        groundedLoopSense,
  input wire logic        supplyOn,
  input wire logic        configMode,
  input wire cpp_led_t    state_indicator_led,
  input wire logic        hvEnable,
  input wire cpp_led_t    upperConnLed,
  input wire cpp_led_t    lowerConnLed,
  input wire logic [3:0]  numberLeds,
  input wire logic [3:0]  chain_position_id,
  input wire logic [11:0] ownAddress
);
  logic [2:0] age;
  logic       live;
  logic       slave;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) age <= 3'h0;
    else if (!live) age <= age + 3'h1;
  end
  // Outputs stay clear a few edges after release, so skip that stretch
  assign live  = age == 3'h5;
  // Orders past four slaves are not a valid chain place
  assign slave = live && !isMaster && chainConnected && chainOrder <= 3'(SLAVES_PER_LINE);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  chk_hv_needs_loop: assert property (
    hvEnable |-> $past(floatingLoopSense && groundedLoopSense)) else $error("hv without loop");
  chk_hv_drop_fast: assert property (
    !(floatingLoopSense && groundedLoopSense) |=> !hvEnable) else $error("hv late off");
  chk_dark_unlinked: assert property (
    (live && !isMaster && !chainConnected)[*2] |-> {upperConnLed, lowerConnLed, numberLeds} == 8'h00)
    else $error("unlinked slave lit");
  chk_order_shown: assert property (
    slave[*2] ##0 $stable({chainOnGreen, chainOrder}) |-> numberLeds == {1'b0, chainOrder})
    else $error("order leds wrong");
  chk_chain_position_id: assert property (
    slave[*2] ##0 $stable({chainOnGreen, chainOrder}) |-> chain_position_id ==
      (chainOnGreen ? GREEN_ID_BASE : YELLOW_ID_BASE) + {1'b0, chainOrder}) else $error("bad id");
  chk_master_conn: assert property (
    (live && isMaster)[*2] |-> upperConnLed == 2'b11 && lowerConnLed == 2'b10) else $error("conn led");
  chk_green_is_on: assert property (
    state_indicator_led == 2'b10 |-> supplyOn || configMode) else $error("green while supply off");
  chk_addr_fixed: assert property (
    live |-> ownAddress == ADDR_CTRL_NEW) else $error("own address wrong");
endmodule

// ===== test/crate_power_panel_control_test.sv
`timescale 1ns/1ps
module crate_power_panel_control_test;
  import cpp_pkg::*;
  logic sys_clk = 1'b0, rst_n = 1'b0, powerButton = 1'b0, remoteOn = 1'b0, remoteOff = 1'b0;
  logic supplyError = 1'b0, cfgDone = 1'b0, isMaster = 1'b0, linkUp = 1'b0, greenLine = 1'b0;
  logic floatingLoopSense = 1'b0, groundedLoopSense = 1'b0, hvRequest = 1'b0, chainConnected;
  logic chainOnGreen, supplyOn, configMode, hvEnable, legacyOverflow;
  logic [2:0] position = 3'h0, chainOrder;
  logic [6:0] legacyModuleCount = 7'h00;
  logic [3:0] numberLeds, chain_position_id;
  logic [11:0] ownAddress;
  cpp_led_t state_indicator_led, upperConnLed, lowerConnLed;
  int fails = 0, samples_checked = 0, cyc = 0;
  int seed = 32'ha7503581;
  always #2.5 sys_clk = ~sys_clk;
  cpp_chain_peer i_peer (.sys_clk, .linkUp, .greenLine, .position, .chainConnected,
    .chainOnGreen, .chainOrder);
  cpp_panel_control #(.HoldOnCyc(200), .HoldCfgCyc(1000), .ErrShowCyc(300), .DebCyc(4)) i_dut (
    .sys_clk, .rst_n, .powerButton, .remoteOn, .remoteOff, .supplyError, .cfgDone, .isMaster,
    .chainConnected, .chainOnGreen, .chainOrder, .floatingLoopSense, .groundedLoopSense,
    .hvRequest, .legacyModuleCount, .supplyOn, .state_indicator_led, .configMode, .hvEnable,
    .upperConnLed, .lowerConnLed, .numberLeds, .chain_position_id, .ownAddress, .legacyOverflow);
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic press(input int n);
    powerButton = 1'b1;
    step(n);
    powerButton = 1'b0;
    step(20);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    step(1);
    s = 1'b0;
    step(6);
  endtask
  function automatic logic hvExp(logic f, logic g, logic h);
    return f & g & h;
  endfunction
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    // Whole sequence needs about 2650 cycles
    if (cyc == 8000) begin
      fails++;
      tally_and_finish;
    end
  end
  initial begin
    step(6);
    rst_n = 1'b1;
    step(4);
    press(50);
    chk(supplyOn, 1'b0);
    press(250);
    chk({supplyOn, state_indicator_led}, 3'b110);
    supplyError = 1'b1;
    step(5);
    chk({supplyOn, state_indicator_led}, 3'b101);
    supplyError = 1'b0;
    press(250);
    chk({supplyOn, state_indicator_led}, 3'b000);
    $display("button toggle tests done");
    supplyError = 1'b1;
    press(250);
    chk({supplyOn, state_indicator_led}, 3'b001);
    step(300);
    chk({supplyOn, state_indicator_led}, 3'b000);
    supplyError = 1'b0;
    pulse(remoteOn);
    chk(supplyOn, 1'b1);
    pulse(remoteOff);
    chk(supplyOn, 1'b0);
    press(1100);
    chk({configMode, supplyOn}, 2'b10);
    pulse(cfgDone);
    chk(configMode, 1'b0);
    $display("error remote config tests done");
    pulse(remoteOn);
    for (int i = 0; i < 300; i++) begin
      {floatingLoopSense, groundedLoopSense, hvRequest} = 3'($random(seed));
      legacyModuleCount = (i < 2) ? 7'h40 + 7'(i) : 7'($random(seed));
      if (i % 4 == 0) {isMaster, linkUp, greenLine, position} = 6'($random(seed));
      step(1);
      chk(hvEnable, hvExp(floatingLoopSense, groundedLoopSense, hvRequest));
      chk(legacyOverflow, legacyModuleCount > 7'h40);
    end
    $display("random hv and chain test done");
    tally_and_finish;
  end
endmodule
bind cpp_panel_control cpp_panel_control_properties i_chk (.sys_clk, .rst_n, .isMaster,
  .chainConnected, .chainOnGreen, .chainOrder, .floatingLoopSense, .groundedLoopSense,
  .supplyOn, .configMode, .state_indicator_led, .hvEnable, .upperConnLed, .lowerConnLed,
  .numberLeds,
  .chain_position_id, .ownAddress);
